// ==== isr_map.svh ====
`ifndef ISR_MAP_SVH
`define ISR_MAP_SVH

// register byte offsets
`define ISR_OFF_REMAP      12'h000
`define ISR_OFF_TGT_SEC    12'h004
`define ISR_OFF_STATUS     12'h008
`define ISR_OFF_PORT_CFG   12'h00c

// reset values
`define ISR_RST_REMAP      8'h00
`define ISR_RST_TGT_SEC    7'h7f

// geometry
`define ISR_NUM_SP         2
`define ISR_NUM_TGT        7
`define ISR_REMAP_W        8
`define ISR_VID_W          4
`define ISR_IID_W          4
`define ISR_GID_W          9
`define ISR_OST_W          4
`define ISR_OST_MAX        4'hf

// global config space window, decode fields
`define ISR_CFG_BASE       20'h7ff00
`define ISR_APB_BASE_TGT   3'h3

// configured per-target kinds (2 bits each, target 6 in the top pair)
// slave0 root, slave1 open, slave2 secure, apb0 root, apb1 open, apb2 root, apb3 secure
`define ISR_TGT_KIND       14'b00_10_01_10_00_01_10
// per-port security source (2 bits each): port0 master signal, port1 forced non-secure
`define ISR_SP_SEC_SRC     4'b10_00
// per-port remap bits that affect its decoder
`define ISR_SP_REMAP_MASK  16'h07_07
// arbitrary interconnect identifier value
`define ISR_IID            4'h5

// axi response codes
`define ISR_RESP_OKAY      2'b00
`define ISR_RESP_DECERR    2'b11

`endif

// ==== isr_pkg.sv ====
package isr_pkg;

   typedef enum logic [1:0] {
      ISR_KIND_SECURE = 2'b00,
      ISR_KIND_OPEN   = 2'b01,
      ISR_KIND_ROOT   = 2'b10
   } isr_kind_e;

   typedef enum logic [1:0] {
      ISR_SRC_MASTER = 2'b00,
      ISR_SRC_SECURE = 2'b01,
      ISR_SRC_NONSEC = 2'b10
   } isr_src_e;

   typedef logic [2:0] isr_tgt_t;

endpackage

// ==== isr_security_remap.sv ====
// How it works
// (R1) each slave port takes security from master signal, forced secure or forced non-secure
// (R2) non-secure config-space accesses get DECERR and touch no register
// (R3) an always-secure target rejects every non-secure transaction
// (R4) an always-open target passes secure and non-secure transactions
// (R5) a root target follows its programmed security bit
// (R6) in-flight transactions and locks keep the old security setting
// (R7) each apb slave behind the apb port has its own security check
// (R8) non-secure to a secure target returns DECERR and is not forwarded
// (R9) security setting waits while a transaction is pending or a lock runs; two ports forwarding to one target in one cycle count as one pending
// (R10) eight remap bits, of which only bits 0 to 2 enable a remap state
// (R11) lower remap bit wins when two states touch the same port
// (R12) remap states alias, move or remove regions, per port
// (R13) a port holds old remap bits until its lock sequence ends
// (R14) remap bits may reach ports one after another
// (R15) after the remap write response the next transaction uses the new map
// (R16) 000 alias, 001 alias removed, 010 slave1 at bottom, 101 slave1 removed
// (R17) each transaction carries global id of interconnect id, virtual id, port id
// (R18) port id field records the originating slave port
// (R19) the attached master drives the virtual id bits
// (R20) config space masters drive prot bit 1 low for secure
// (R21) remap bits reset to zero, power-up alias active
`timescale 1ns/1ps
`include "isr_map.svh"

module isr_security_remap
   import isr_pkg::*;
(
   input  wire logic                                         aclk,
   input  wire logic                                         aresetn,
   input  wire logic                                         s_axi_awvalid,
   output logic                                              s_axi_awready,
   input  wire logic [31:0]                                  s_axi_awaddr,
   input  wire logic [2:0]                                   s_axi_awprot,
   input  wire logic                                         s_axi_wvalid,
   output logic                                              s_axi_wready,
   input  wire logic [31:0]                                  s_axi_wdata,
   input  wire logic [3:0]                                   s_axi_wstrb,
   output logic                                              s_axi_bvalid,
   input  wire logic                                         s_axi_bready,
   output logic [1:0]                                        s_axi_bresp,
   input  wire logic                                         s_axi_arvalid,
   output logic                                              s_axi_arready,
   input  wire logic [31:0]                                  s_axi_araddr,
   input  wire logic [2:0]                                   s_axi_arprot,
   output logic                                              s_axi_rvalid,
   input  wire logic                                         s_axi_rready,
   output logic [31:0]                                       s_axi_rdata,
   output logic [1:0]                                        s_axi_rresp,
   input  wire logic [`ISR_NUM_SP-1:0]                       sp_req_valid,
   input  wire logic [`ISR_NUM_SP-1:0][31:0]                 sp_req_addr,
   input  wire logic [`ISR_NUM_SP-1:0]                       sp_req_nonsec,
   input  wire logic [`ISR_NUM_SP-1:0]                       sp_req_lock,
   input  wire logic [`ISR_NUM_SP-1:0][`ISR_VID_W-1:0]       sp_req_vid,
   output logic [`ISR_NUM_SP-1:0]                            sp_req_ready,
   output logic [`ISR_NUM_SP-1:0]                            sp_out_valid,
   output logic [`ISR_NUM_SP-1:0][2:0]                       sp_out_target,
   output logic [`ISR_NUM_SP-1:0]                            sp_out_decerr,
   output logic [`ISR_NUM_SP-1:0]                            sp_out_nonsec,
   output logic [`ISR_NUM_SP-1:0][`ISR_GID_W-1:0]            sp_out_gid,
   input  wire logic [`ISR_NUM_TGT-1:0]                      tgt_done
);

   localparam int NSP = `ISR_NUM_SP;
   localparam int NT  = `ISR_NUM_TGT;

   // register file
   logic [`ISR_REMAP_W-1:0]     remap_r;
   logic [NT-1:0]               tgt_sec_r;
   logic [NT-1:0]               tgt_sec_eff_r;
   logic [NSP-1:0]              lock_act_r;
   logic [NSP-1:0][`ISR_REMAP_W-1:0] sp_remap_hold_r;
   logic [NT-1:0][`ISR_OST_W-1:0]    ost_r;

   // axi-lite slave state
   logic                        aw_held_r;
   logic [31:0]                 awaddr_r;
   logic                        aw_ns_r;
   logic                        w_held_r;
   logic [31:0]                 wdata_r;
   logic [3:0]                  wstrb_r;
   logic                        do_write;
   logic                        wr_hit_remap;
   logic                        wr_hit_sec;
   logic                        wr_mapped;
   logic                        rd_mapped;
   logic [31:0]                 rd_word;

   // per-port decode results
   logic [NSP-1:0]              dec_hit;
   logic [NSP-1:0][2:0]         dec_tgt;
   logic [NSP-1:0]              req_ns;
   logic [NSP-1:0]              req_reject;
   logic [NSP-1:0]              req_fwd;
   logic                        any_pending;

   function automatic logic is_cfg(input logic [31:0] a);
      is_cfg = (a[31:12] == `ISR_CFG_BASE);
   endfunction

   function automatic logic reg_known(input logic [31:0] a);
      reg_known = is_cfg(a) && a[1:0] == 2'b00 &&
                  (a[11:0] == `ISR_OFF_REMAP || a[11:0] == `ISR_OFF_TGT_SEC ||
                   a[11:0] == `ISR_OFF_STATUS || a[11:0] == `ISR_OFF_PORT_CFG);
   endfunction

   // address decoder with remap states; bit order gives precedence
   function automatic logic [3:0] decode(input logic [31:0] a, input logic [`ISR_REMAP_W-1:0] rm);
      logic [2:0] apb;
      apb    = `ISR_APB_BASE_TGT + {1'b0, a[27:26]};
      decode = 4'h0;
      unique case (a[31:28])
         4'h0: begin
            if (rm[0]) begin // R11
               decode = {1'b1, `ISR_APB_BASE_TGT}; // R16
            end else if (rm[1]) begin
               decode = rm[2] ? 4'h0 : 4'h9; // R12
            end else begin
               decode = 4'h8; // R16
            end
         end
         4'h2, 4'h3: decode = 4'h8;
         4'h4:       decode = rm[2] ? 4'h0 : 4'h9; // R16
         4'h5:       decode = 4'ha;
         4'h6:       decode = {1'b1, apb}; // R7
         default:    decode = 4'h0;
      endcase
   endfunction

   function automatic logic tgt_is_secure(input int t, input logic [NT-1:0] eff);
      isr_kind_e k;
      k = isr_kind_e'(2'(`ISR_TGT_KIND >> (2 * t)));
      unique case (k)
         ISR_KIND_SECURE: tgt_is_secure = 1'b1; // R3
         ISR_KIND_OPEN:   tgt_is_secure = 1'b0; // R4
         ISR_KIND_ROOT:   tgt_is_secure = eff[t]; // R5
         default:         tgt_is_secure = 1'b1;
      endcase
   endfunction

   // ---------------- register bus ----------------

   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_mapped     = reg_known(awaddr_r);
   // non-secure writes hit nothing and answer decerr
   assign wr_hit_remap  = do_write && !aw_ns_r && wr_mapped && awaddr_r[11:0] == `ISR_OFF_REMAP; // R2
   assign wr_hit_sec    = do_write && !aw_ns_r && wr_mapped && awaddr_r[11:0] == `ISR_OFF_TGT_SEC; // R2

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= 32'h0000_0000;
         aw_ns_r   <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
         aw_ns_r   <= s_axi_awprot[1]; // R20
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ISR_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_ns_r || !wr_mapped) ? `ISR_RESP_DECERR : `ISR_RESP_OKAY; // R2
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // the remap value moves with the write, so the response already sees it in force
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         remap_r <= `ISR_RST_REMAP; // R21
      end else if (wr_hit_remap && wstrb_r[0]) begin
         remap_r <= wdata_r[`ISR_REMAP_W-1:0]; // R10 R15
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tgt_sec_r <= `ISR_RST_TGT_SEC;
      end else if (wr_hit_sec && wstrb_r[0]) begin
         tgt_sec_r <= wdata_r[NT-1:0];
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
   assign rd_mapped     = reg_known(s_axi_araddr);

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr[11:0])
         `ISR_OFF_REMAP:    rd_word = {24'h00_0000, remap_r};
         `ISR_OFF_TGT_SEC:  rd_word = {25'h000_0000, tgt_sec_r};
         `ISR_OFF_STATUS:   rd_word = {22'h00_0000, lock_act_r, 1'b0, tgt_sec_eff_r};
         `ISR_OFF_PORT_CFG: rd_word = {24'h00_0000, 4'h0, `ISR_SP_SEC_SRC};
         default:           rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `ISR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         if (s_axi_arprot[1] || !rd_mapped) begin
            s_axi_rdata <= 32'h0000_0000; // R2
            s_axi_rresp <= `ISR_RESP_DECERR; // R2
         end else begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= `ISR_RESP_OKAY;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- security setting ----------------

   always_comb begin
      any_pending = |lock_act_r;
      for (int t = 0; t < NT; t++) begin
         any_pending = any_pending || (ost_r[t] != '0);
      end
   end

   // the checked setting only follows the register when no lock runs, nothing is forwarded and every outstanding count is zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tgt_sec_eff_r <= `ISR_RST_TGT_SEC;
      end else if (!any_pending && !(|req_fwd)) begin // R9
         tgt_sec_eff_r <= tgt_sec_r; // R6
      end
   end

   // outstanding count per target; saturates rather than wraps
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ost_r <= '0;
      end else begin
         for (int t = 0; t < NT; t++) begin
            logic inc;
            inc = 1'b0;
            for (int p = 0; p < NSP; p++) begin
               inc = inc || (req_fwd[p] && dec_tgt[p] == t[2:0]);
            end
            if (inc && !tgt_done[t] && ost_r[t] != `ISR_OST_MAX) begin
               ost_r[t] <= ost_r[t] + 4'h1;
            end else if (!inc && tgt_done[t] && ost_r[t] != '0) begin
               ost_r[t] <= ost_r[t] - 4'h1;
            end
         end
      end
   end

   // ---------------- slave ports ----------------

   // requests are taken every cycle; two ports forwarding to one target together count as one outstanding
   assign sp_req_ready = {NSP{1'b1}};

   for (genvar p = 0; p < NSP; p++) begin : g_sp
      logic [`ISR_REMAP_W-1:0] rm_use;
      logic [3:0]              d;
      isr_src_e                src;

      assign src    = isr_src_e'(2'(`ISR_SP_SEC_SRC >> (2 * p)));
      // live remap outside a lock, frozen copy inside it
      assign rm_use = (lock_act_r[p] ? sp_remap_hold_r[p] : remap_r) & // R13 R14
                      `ISR_REMAP_W'(`ISR_SP_REMAP_MASK >> (`ISR_REMAP_W * p)); // R12
      assign d       = decode(sp_req_addr[p], rm_use);
      assign dec_hit[p] = d[3];
      assign dec_tgt[p] = d[2:0];
      assign req_ns[p]  = (src == ISR_SRC_NONSEC) ||
                          (src == ISR_SRC_MASTER && sp_req_nonsec[p]); // R1
      assign req_reject[p] = !dec_hit[p] ||
                             (req_ns[p] && tgt_is_secure(int'(dec_tgt[p]), tgt_sec_eff_r)); // R8
      assign req_fwd[p] = sp_req_valid[p] && !req_reject[p];

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            lock_act_r[p] <= 1'b0;
         end else if (sp_req_valid[p]) begin
            lock_act_r[p] <= sp_req_lock[p];
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            sp_remap_hold_r[p] <= `ISR_RST_REMAP;
         end else if (!lock_act_r[p]) begin
            sp_remap_hold_r[p] <= remap_r; // R13
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            sp_out_valid[p]  <= 1'b0;
            sp_out_target[p] <= 3'h0;
            sp_out_decerr[p] <= 1'b0;
            sp_out_nonsec[p] <= 1'b0;
            sp_out_gid[p]    <= '0;
         end else begin
            sp_out_valid[p] <= sp_req_valid[p];
            if (sp_req_valid[p]) begin
               sp_out_target[p] <= dec_tgt[p];
               sp_out_decerr[p] <= req_reject[p]; // R8
               sp_out_nonsec[p] <= req_ns[p];
               sp_out_gid[p]    <= {`ISR_IID, sp_req_vid[p], 1'(p)}; // R17 R18 R19
            end
         end
      end
   end

endmodule // isr_security_remap

// ==== isr_far_tgt.sv ====
`timescale 1ns/1ps
`include "isr_map.svh"

module isr_far_tgt
   import isr_pkg::*;
(
   input  logic                          aclk,
   input  logic                          aresetn,
   input  logic                          slow,
   input  logic [`ISR_NUM_SP-1:0]        out_valid,
   input  logic [`ISR_NUM_SP-1:0]        out_decerr,
   input  logic [`ISR_NUM_SP-1:0][2:0]   out_target,
   output logic [`ISR_NUM_TGT-1:0]       tgt_done
);
   int pend [`ISR_NUM_TGT];
   int tmr  [`ISR_NUM_TGT];

   // slaves finish in arrival order; slow keeps a transfer open across a register update
   always @(posedge aclk) begin
      tgt_done <= '0;
      for (int t = 0; t < `ISR_NUM_TGT; t++) begin
         for (int p = 0; p < `ISR_NUM_SP; p++)
            if (out_valid[p] && !out_decerr[p] && out_target[p] == 3'(t))
               pend[t]++;
         if (!aresetn)
            pend[t] = 0;
         if (pend[t] == 0)
            tmr[t] = slow ? 30 : 1;
         else if (tmr[t] > 0)
            tmr[t]--;
         else begin
            tgt_done[t] <= 1'b1;
            pend[t]--;
            tmr[t] = slow ? 30 : 1;
         end
      end
   end
endmodule // isr_far_tgt

// ==== isr_checker.sv ====
`timescale 1ns/1ps
`include "isr_map.svh"

module isr_checker
   import isr_pkg::*;
(
   input logic                aclk,
   input logic                aresetn,
   input logic                s_axi_awvalid,
   input logic                s_axi_awready,
   input logic [2:0]          s_axi_awprot,
   input logic                s_axi_wvalid,
   input logic                s_axi_wready,
   input logic                s_axi_bvalid,
   input logic [1:0]          s_axi_bresp,
   input logic                s_axi_arvalid,
   input logic                s_axi_arready,
   input logic [2:0]          s_axi_arprot,
   input logic                s_axi_rvalid,
   input logic [31:0]         s_axi_rdata,
   input logic [1:0]          s_axi_rresp,
   input logic [1:0]          sp_req_valid,
   input logic [1:0][31:0]    sp_req_addr,
   input logic [1:0]          sp_req_nonsec,
   input logic [1:0][3:0]     sp_req_vid,
   input logic [1:0]          sp_out_valid,
   input logic [1:0][2:0]     sp_out_target,
   input logic [1:0]          sp_out_decerr,
   input logic [1:0]          sp_out_nonsec,
   input logic [1:0][8:0]     sp_out_gid
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic aw_ns_r;

   // prot of the write address taken last, judged when its response appears
   always_ff @(posedge aclk)
      if (s_axi_awvalid && s_axi_awready)
         aw_ns_r <= s_axi_awprot[1];

   chk_gid_port0: assert property (sp_req_valid[0] |=> sp_out_valid[0] &&
      sp_out_gid[0] == {`ISR_IID, $past(sp_req_vid[0]), 1'b0}) else $error("port0 global id wrong");
   chk_gid_port1: assert property (sp_req_valid[1] |=> sp_out_valid[1] &&
      sp_out_gid[1] == {`ISR_IID, $past(sp_req_vid[1]), 1'b1}) else $error("port1 global id wrong");
   chk_forced_nonsec: assert property (sp_out_valid[1] |-> sp_out_nonsec[1])
      else $error("port1 not forced non-secure");
   chk_master_nonsec: assert property (sp_req_valid[0] |=> sp_out_nonsec[0] == $past(sp_req_nonsec[0]))
      else $error("port0 security not from master");
   chk_secure_target: assert property (sp_req_valid[1] && sp_req_addr[1][31:28] == 4'h5 |=> sp_out_decerr[1])
      else $error("non-secure reached secure target");
   chk_apb_open: assert property (sp_req_valid[1] && sp_req_addr[1][31:26] == 6'h19 |=>
      !sp_out_decerr[1] && sp_out_target[1] == 3'h4) else $error("open apb slave refused");
   chk_apb_secure: assert property (sp_req_valid[1] && sp_req_addr[1][31:26] == 6'h1b |=> sp_out_decerr[1])
      else $error("secure apb slave passed non-secure");
   chk_cfg_read_ns: assert property (s_axi_arvalid && s_axi_arready && s_axi_arprot[1] |=> s_axi_rvalid &&
      s_axi_rresp == `ISR_RESP_DECERR && s_axi_rdata == 32'h0) else $error("non-secure read not refused");
   chk_cfg_write_ns: assert property ($rose(s_axi_bvalid) && aw_ns_r |-> s_axi_bresp == `ISR_RESP_DECERR)
      else $error("non-secure write not refused");
   chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");

   cov_port0_refused: cover property (sp_out_valid[0] && sp_out_decerr[0]);
   cov_port1_passed: cover property (sp_out_valid[1] && !sp_out_decerr[1]);
   cov_cfg_refused: cover property (s_axi_bvalid && s_axi_bresp == `ISR_RESP_DECERR);
endmodule // isr_checker

bind isr_security_remap isr_checker i_isr_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awprot,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_arprot,
   .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .sp_req_valid, .sp_req_addr, .sp_req_nonsec, .sp_req_vid,
   .sp_out_valid, .sp_out_target, .sp_out_decerr, .sp_out_nonsec, .sp_out_gid);

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "isr_map.svh"

module tb_top import isr_pkg::*;;
   logic              aclk, aresetn, slow;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0]       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [2:0]        s_axi_awprot, s_axi_arprot;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic [1:0]        sp_req_valid, sp_req_nonsec, sp_req_lock, sp_req_ready;
   logic [1:0]        sp_out_valid, sp_out_decerr, sp_out_nonsec;
   logic [1:0][31:0]  sp_req_addr;
   logic [1:0][3:0]   sp_req_vid;
   logic [1:0][2:0]   sp_out_target;
   logic [1:0][8:0]   sp_out_gid;
   logic [6:0]        tgt_done;
   int                bad_count, comparisons;
   logic [2:0]        map0 [6] = '{3'h0, 3'h3, 3'h1, 3'h3, 3'h0, 3'h3};
   logic [31:0]       taddr [7] = '{32'h2000_0000, 32'h4000_0000, 32'h5000_0000, 32'h6000_0000,
                                    32'h6400_0000, 32'h6800_0000, 32'h6c00_0000};

   isr_security_remap i_isr_security_remap (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .sp_req_valid, .sp_req_addr, .sp_req_nonsec, .sp_req_lock, .sp_req_vid,
      .sp_req_ready, .sp_out_valid, .sp_out_target, .sp_out_decerr, .sp_out_nonsec, .sp_out_gid, .tgt_done);
   isr_far_tgt i_isr_far_tgt (.aclk, .aresetn, .slow, .out_valid(sp_out_valid), .out_decerr(sp_out_decerr),
      .out_target(sp_out_target), .tgt_done);

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ready is looked at mid-cycle, where it already equals what the next edge samples
   task automatic axi_wr(input logic [11:0] off, input logic [31:0] d, input logic [2:0] p, input logic [1:0] er);
      logic aw_ok, w_ok, aw_hs, w_hs, bv;
      logic [1:0] br;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= {`ISR_CFG_BASE, off};
      s_axi_awprot <= p;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(negedge aclk);
         aw_hs = !aw_ok && s_axi_awready;
         w_hs = !w_ok && s_axi_wready;
         @(posedge aclk);
         s_axi_awvalid <= !aw_ok && !aw_hs;
         s_axi_wvalid <= !w_ok && !w_hs;
         aw_ok = aw_ok | aw_hs;
         w_ok = w_ok | w_hs;
      end
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         bv = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge aclk);
      end while (!bv);
      s_axi_bready <= 1'b0;
      cmp(br, er);
   endtask

   task automatic axi_rd(input logic [11:0] off, input logic [2:0] p, input logic [31:0] ed, input logic [1:0] er);
      logic hs;
      logic [31:0] rd;
      logic [1:0] rr;
      s_axi_araddr <= {`ISR_CFG_BASE, off};
      s_axi_arprot <= p;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         hs = s_axi_arready;
         @(posedge aclk);
      end while (!hs);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         hs = s_axi_rvalid;
         rd = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge aclk);
      end while (!hs);
      s_axi_rready <= 1'b0;
      cmp(rd, ed);
      cmp(rr, er);
   endtask

   task automatic sp(input int p, input logic [31:0] a, input logic ns, input logic lk, input logic [3:0] v,
                     input logic [2:0] et, input logic ed);
      sp_req_addr[p] <= a;
      sp_req_nonsec[p] <= ns;
      sp_req_lock[p] <= lk;
      sp_req_vid[p] <= v;
      sp_req_valid[p] <= 1'b1;
      @(posedge aclk);
      sp_req_valid[p] <= 1'b0;
      @(negedge aclk);
      cmp(sp_req_ready[p], 1'b1);
      cmp(sp_out_valid[p], 1'b1);
      cmp(sp_out_decerr[p], ed);
      if (!ed)
         cmp(sp_out_target[p], et);
      @(posedge aclk);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #40000;
      bad_count++;
      report_and_stop;
   end

   initial begin
      {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
      {sp_req_valid, sp_req_nonsec, sp_req_lock, sp_req_addr, sp_req_vid} = '0;
      s_axi_wstrb = 4'hf;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(12'h000, 3'h0, 32'h0, `ISR_RESP_OKAY);
      axi_rd(12'h004, 3'h0, 32'h7f, `ISR_RESP_OKAY);
      axi_rd(12'h008, 3'h0, 32'h7f, `ISR_RESP_OKAY);
      axi_rd(12'h00c, 3'h0, 32'h8, `ISR_RESP_OKAY);
      axi_rd(12'h010, 3'h0, 32'h0, `ISR_RESP_DECERR);
      axi_wr(12'h000, 32'h1, 3'h2, `ISR_RESP_DECERR);
      axi_rd(12'h000, 3'h2, 32'h0, `ISR_RESP_DECERR);
      axi_rd(12'h000, 3'h0, 32'h0, `ISR_RESP_OKAY);
      axi_wr(12'h000, 32'h80, 3'h0, `ISR_RESP_OKAY);
      axi_rd(12'h000, 3'h0, 32'h80, `ISR_RESP_OKAY);
      sp(0, 32'h0, 1'b0, 1'b0, 4'h3, 3'h0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         axi_wr(12'h000, 32'(i), 3'h0, `ISR_RESP_OKAY);
         sp(0, 32'h0, 1'b0, 1'b0, 4'(i), map0[i], 1'b0);
         sp(0, 32'h4000_0000, 1'b0, 1'b0, 4'(i + 8), 3'h1, i >= 4);
      end
      axi_wr(12'h000, 32'h0, 3'h0, `ISR_RESP_OKAY);
      for (int s = 0; s < 2; s++) begin
         for (int t = 0; t < 7; t++)
            sp(1, taddr[t], 1'b0, 1'b0, 4'(t), 3'(t), 1'((s ? 7'b1000100 : 7'b1101101) >> t));
         axi_wr(12'h004, 32'h0, 3'h0, `ISR_RESP_OKAY);
         axi_rd(12'h008, 3'h0, 32'h0, `ISR_RESP_OKAY);
      end
      sp(0, 32'h5000_0000, 1'b1, 1'b0, 4'h6, 3'h2, 1'b1);
      sp(0, 32'h5000_0000, 1'b0, 1'b0, 4'h7, 3'h2, 1'b0);
      slow <= 1'b1;
      sp(1, 32'h2000_0000, 1'b0, 1'b0, 4'h1, 3'h0, 1'b0);
      axi_wr(12'h004, 32'h7f, 3'h0, `ISR_RESP_OKAY);
      axi_rd(12'h008, 3'h0, 32'h0, `ISR_RESP_OKAY);
      sp(1, 32'h2000_0000, 1'b0, 1'b0, 4'h2, 3'h0, 1'b0);
      repeat (80) @(posedge aclk);
      slow <= 1'b0;
      axi_rd(12'h008, 3'h0, 32'h7f, `ISR_RESP_OKAY);
      sp(1, 32'h2000_0000, 1'b0, 1'b0, 4'h3, 3'h0, 1'b1);
      sp(0, 32'h0, 1'b0, 1'b1, 4'h2, 3'h0, 1'b0);
      axi_wr(12'h000, 32'h1, 3'h0, `ISR_RESP_OKAY);
      axi_rd(12'h008, 3'h0, 32'h17f, `ISR_RESP_OKAY);
      sp(0, 32'h0, 1'b0, 1'b1, 4'h2, 3'h0, 1'b0);
      sp(0, 32'h2000_0000, 1'b0, 1'b0, 4'h2, 3'h0, 1'b0);
      sp(0, 32'h0, 1'b0, 1'b0, 4'h4, 3'h3, 1'b0);
      report_and_stop;
   end
endmodule // tb_top
